// file: rtl/pcs_status.sv
// bus event status word with parity response enable of the command word
// Summary of operation
// - status word read-only at offset 06h
// - parity error sets bit 15 always
// - system error drive sets bit 14
// - master-abort sets bit 13, not special cycles
// - received target-abort as master sets bit 12
// - own target-abort as target sets bit 11
// - select timing coded fast, medium, slow only
// - bits 10:9 report slowest select response
// - master parity bit 8 needs three conditions
// - bit 7 reads zero without that capability
// - bit 5 reports 33 MHz only
// - bit 4 set, capability pointer at 34h
// - parity response enable resets low, gates error line
`timescale 1ns/1ps
`default_nettype none
`include "pcs_params.svh"

module pcs_status (
    input  wire logic                  clk_in,      // bus clock, 40 MHz
    input  wire logic                  rst_n_in,    // sync reset, active low
    input  wire pcs_pkg::pcs_event_s   event_in,    // bus event strobes
    input  wire pcs_pkg::pcs_cfg_req_s cfg_in,      // configuration access
    output logic                       cfg_ack_out, // read data valid
    output logic [31:0]                cfg_rdata_out, // read data
    output logic                       perr_drive_out, // drive error line
    output logic                       per_out,     // parity response enable
    output pcs_pkg::pcs_word_t         status_out   // live status word
);
    import pcs_pkg::*;

    // interface timing at a glance:
    // - a read strobe is taken on the rising edge where it is high
    // - the acknowledge and read data follow one cycle later
    // - acknowledge and read data stand for that one cycle only
    // - a read and a write may come back to back, every cycle
    // - a read and a write in one cycle return the old value
    // - event strobes are taken on every edge where they are high
    // - a flag shows in the live word one cycle after its event
    // - the low two address bits are ignored by the decode
    // - the status word sits in the upper half of dword 04h
    // - the command half keeps only the parity response enable

    // sticky event flags, one per recorded bus event
    logic [`PCS_NUM_FLAGS-1:0] flags_q;
    logic [`PCS_NUM_FLAGS-1:0] flags_d;
    logic [`PCS_NUM_FLAGS-1:0] flag_set;

    // parity response enable kept from the command word
    logic                      resp_en_q;
    logic                      resp_en_d;
    logic                      resp_en_write;

    // registered read answer
    logic                      ack_q;
    logic                      ack_d;
    logic [31:0]               rdata_q;
    logic [31:0]               rdata_d;

    // assembled words
    pcs_word_t                 status_word;
    pcs_word_t                 cmd_word;
    logic [1:0]                sel_timing;

    // request decode
    logic                      dword_hit;
    logic                      read_hit;
    logic                      low_byte_en;

    // qualified event conditions
    logic                      perr_drive;
    logic                      parity_set;
    logic                      syserr_set;
    logic                      master_abort_ok;
    logic                      rx_abort_ok;
    logic                      tx_abort_ok;
    logic                      error_line_event;
    logic                      master_parity_set;

    // the error line is only driven while parity response is enabled;
    // with it off the function keeps running and only records the error
    assign perr_drive = event_in.perr_req_read
                      & resp_en_q;

    // a detected parity error is recorded in any role and whatever
    // the response enable says
    assign parity_set = event_in.parity_err_det;

    // the engine strobes this in every cycle it asserts the system
    // error line, so repeats only re-set an already set flag
    assign syserr_set = event_in.serr_driven;

    // master-abort counts only for our own cycles and never for a
    // special cycle, which has no target to claim it
    assign master_abort_ok = event_in.master_abort
                           & event_in.is_master
                           & ~event_in.special_cycle;

    // a target-abort received counts only while we own the bus
    assign rx_abort_ok = event_in.target_abort_rx
                       & event_in.is_master;

    // a target-abort we signal counts only while we are the target
    assign tx_abort_ok = event_in.target_abort_tx
                       & ~event_in.is_master;

    // first condition: we drove the error line on a read, or saw it
    // on a write; a read only counts once the line is really driven
    assign error_line_event = perr_drive
                            | event_in.perr_seen_write;

    // all three conditions must meet in the same cycle
    assign master_parity_set = error_line_event
                             & event_in.is_master
                             & resp_en_q;

    // set conditions gathered into one vector by flag index
    assign flag_set[`PCS_FLAG_PARITY]   = parity_set;
    assign flag_set[`PCS_FLAG_SYSERR]   = syserr_set;
    assign flag_set[`PCS_FLAG_MABORT]   = master_abort_ok;
    assign flag_set[`PCS_FLAG_RX_ABORT] = rx_abort_ok;
    assign flag_set[`PCS_FLAG_TX_ABORT] = tx_abort_ok;
    assign flag_set[`PCS_FLAG_MPARITY]  = master_parity_set;

    // flags are sticky; the word is read-only, so only reset clears
    // them and no set-versus-clear race can arise
    genvar gi;
    generate
        for (gi = 0; gi < `PCS_NUM_FLAGS; gi = gi + 1)
        begin : g_flag
            assign flags_d[gi] = flags_q[gi] | flag_set[gi];
        end
    endgenerate

    // timing is a fixed choice; the reserved code can never be
    // selected, and medium is the slowest claim this function makes
    assign sel_timing = `PCS_SEL_TIMING;

    // assemble the status word; reserved bits 6 and 3:0 read zero
    always_comb
    begin
        status_word = `PCS_WORD_ZERO;
        status_word[`PCS_PARITY_POS] =
            flags_q[`PCS_FLAG_PARITY];
        status_word[`PCS_SYSERR_POS] =
            flags_q[`PCS_FLAG_SYSERR];
        status_word[`PCS_MABORT_POS] =
            flags_q[`PCS_FLAG_MABORT];
        status_word[`PCS_RX_ABORT_POS] =
            flags_q[`PCS_FLAG_RX_ABORT];
        status_word[`PCS_TX_ABORT_POS] =
            flags_q[`PCS_FLAG_TX_ABORT];
        status_word[`PCS_MPARITY_POS] =
            flags_q[`PCS_FLAG_MPARITY];
        status_word[`PCS_SEL_HI_POS:`PCS_SEL_LO_POS] =
            sel_timing;
        status_word[`PCS_BIT_FBB_POS] =
            `PCS_FBB_VALUE;
        status_word[`PCS_BIT_66M_POS] =
            `PCS_66M_VALUE;
        status_word[`PCS_BIT_CAP_POS] =
            `PCS_CAP_VALUE;
    end

    // only the parity response enable is kept of the command word;
    // the other command bits belong to other logic and read zero
    always_comb
    begin
        cmd_word = `PCS_WORD_ZERO;
        cmd_word[`PCS_CMD_RESP_POS] = resp_en_q;
    end

    // decode: status shares the dword at 04h with the command word;
    // the low two address bits pick a byte and are ignored here
    assign dword_hit = ((cfg_in.addr & `PCS_DWORD_MASK)
                       == `PCS_CMD_OFFSET);

    // only byte lane 0 carries the response enable
    assign low_byte_en = cfg_in.be[`PCS_CMD_LANE];

    // writes to the status half are dropped: it is read-only
    assign resp_en_write = cfg_in.wr
                         & dword_hit
                         & low_byte_en;
    assign resp_en_d = resp_en_write
                     ? cfg_in.wdata[`PCS_CMD_RESP_POS]
                     : resp_en_q;

    // every read is acknowledged; other offsets belong to other
    // registers and read as zero here, never as an error
    assign read_hit = cfg_in.rd & dword_hit;
    assign ack_d    = cfg_in.rd;
    assign rdata_d  = read_hit
                    ? {status_word, cmd_word}
                    : `PCS_RDATA_RESET;

    // sticky flags; cleared by reset so the word reads 0210h
    // together with the fixed capability bits
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            flags_q <= `PCS_FLAGS_RESET;
        end
        else
        begin
            flags_q <= flags_d;
        end
    end

    // parity response enable; off after reset, so the error line
    // stays quiet until software turns it on
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            resp_en_q <= `PCS_PER_RESET;
        end
        else
        begin
            resp_en_q <= resp_en_d;
        end
    end

    // read acknowledge, a one-cycle pulse after the read strobe
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= ack_d;
        end
    end

    // read data; zero between reads so a stale word is never seen
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            rdata_q <= `PCS_RDATA_RESET;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    // outputs; the live word is combinational from flags and
    // constants, so it already shows a flag one cycle after its event
    assign cfg_ack_out    = ack_q;
    assign cfg_rdata_out  = rdata_q;
    assign perr_drive_out = perr_drive;
    assign per_out        = resp_en_q;
    assign status_out     = status_word;

endmodule
`default_nettype wire

// file: shared/pcs_params.svh
// named offsets, field positions and fixed values of the bus status word
`ifndef PCS_PARAMS_SVH
`define PCS_PARAMS_SVH

// configuration space byte offsets
`define PCS_CMD_OFFSET      8'h04
`define PCS_STATUS_OFFSET   8'h06
`define PCS_DWORD_MASK      8'hFC

// status word field positions
`define PCS_PARITY_POS      15
`define PCS_SYSERR_POS      14
`define PCS_MABORT_POS      13
`define PCS_RX_ABORT_POS    12
`define PCS_TX_ABORT_POS    11
`define PCS_SEL_HI_POS      10
`define PCS_SEL_LO_POS      9
`define PCS_MPARITY_POS     8
`define PCS_BIT_FBB_POS     7
`define PCS_BIT_66M_POS     5
`define PCS_BIT_CAP_POS     4

// sticky flag indices inside the flag register
`define PCS_FLAG_PARITY     5
`define PCS_FLAG_SYSERR     4
`define PCS_FLAG_MABORT     3
`define PCS_FLAG_RX_ABORT   2
`define PCS_FLAG_TX_ABORT   1
`define PCS_FLAG_MPARITY    0

// command word position of the parity response enable
`define PCS_CMD_RESP_POS    6
`define PCS_CMD_LANE        0
`define PCS_WORD_ZERO       16'h0000

// select timing encodings
`define PCS_SEL_FAST        2'h0
`define PCS_SEL_MEDIUM      2'h1
`define PCS_SEL_SLOW        2'h2

// fixed capability values reported by this function
`define PCS_SEL_TIMING      `PCS_SEL_MEDIUM
`define PCS_FBB_VALUE       1'h0
`define PCS_66M_VALUE       1'h0
`define PCS_CAP_VALUE       1'h1

// reset values
`define PCS_STATUS_RESET    16'h0210
`define PCS_FLAGS_RESET     6'h00
`define PCS_PER_RESET       1'h0
`define PCS_RDATA_RESET     32'h0000_0000
`define PCS_NUM_FLAGS       6

`endif

// file: shared/pcs_pkg.sv
// types shared by the bus status word block and its bench
package pcs_pkg;

    // one-cycle event strobes from the bus engine
    typedef struct packed {
        logic parity_err_det;   // parity error seen on any phase
        logic serr_driven;      // system error line asserted this cycle
        logic master_abort;     // own master cycle ended in master-abort
        logic special_cycle;    // qualifies master_abort as special cycle
        logic target_abort_rx;  // own master cycle ended in target-abort
        logic target_abort_tx;  // we ended a target cycle by target-abort
        logic perr_seen_write;  // error line seen during our write
        logic perr_req_read;    // wish to assert error line on our read
        logic is_master;        // we own the bus for this cycle
    } pcs_event_s;

    // configuration access request
    typedef struct packed {
        logic        rd;        // read strobe, one cycle
        logic        wr;        // write strobe, one cycle
        logic [7:0]  addr;      // byte offset in configuration space
        logic [3:0]  be;        // byte enables, active high
        logic [31:0] wdata;     // write data
    } pcs_cfg_req_s;

    typedef logic [15:0] pcs_word_t;

endpackage

// file: testbench/pcs_host_model.sv
// host bridge model issuing configuration cycles
`timescale 1ns/1ps
`default_nettype none
module pcs_host_model (
    input  wire logic                  clk_in,   // bus clock
    input  wire pcs_pkg::pcs_cfg_req_s req_in,   // request from bench
    input  wire logic                  ack_in,   // read valid
    input  wire logic [31:0]           rdata_in, // read data
    output pcs_pkg::pcs_cfg_req_s      cfg_out,  // request on the bus
    output logic [31:0]                data_out, // captured read data
    output logic                       done_out  // read finished
);
    import pcs_pkg::*;
    // idle cycles scramble address and data so stale values never match
    always_ff @(posedge clk_in)
    begin
        cfg_out  <= (req_in.rd | req_in.wr) ? req_in
                    : pcs_cfg_req_s'({2'h0, ~cfg_out[43:0]});
        done_out <= ack_in;
        if (ack_in) data_out <= rdata_in;
    end
endmodule
`default_nettype wire

// file: testbench/pcs_status_sva.sv
// assertions on the ports of the bus status word block
`timescale 1ns/1ps
`default_nettype none
module pcs_status_sva (
    input wire logic                  clk_in,         // bus clock
    input wire logic                  rst_n_in,       // sync reset
    input wire pcs_pkg::pcs_event_s   event_in,       // event strobes
    input wire pcs_pkg::pcs_cfg_req_s cfg_in,         // config request
    input wire logic                  cfg_ack_out,    // read valid
    input wire logic [31:0]           cfg_rdata_out,  // read data
    input wire logic                  perr_drive_out, // error line
    input wire logic                  per_out,        // response enable
    input wire pcs_pkg::pcs_word_t    status_out      // live word
);
    import pcs_pkg::*;
    // one domain, so clock and reset are given once
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    parity_flag_a: assert property (
        event_in.parity_err_det |=> status_out[15])
        else $error("parity flag not set");
    serr_flag_a: assert property (
        event_in.serr_driven |=> status_out[14])
        else $error("system error flag not set");
    master_abort_a: assert property (event_in.master_abort &&
        !event_in.special_cycle && event_in.is_master |=> status_out[13])
        else $error("master abort flag not set");
    rx_abort_a: assert property (event_in.target_abort_rx &&
        event_in.is_master |=> status_out[12])
        else $error("received abort flag not set");
    tx_abort_a: assert property (event_in.target_abort_tx &&
        !event_in.is_master |=> status_out[11])
        else $error("signalled abort flag not set");
    master_parity_a: assert property (
        event_in.is_master && per_out && (event_in.perr_seen_write
        || event_in.perr_req_read) |=> status_out[8])
        else $error("master parity flag not set");
    fixed_bits_a: assert property (
        status_out[10:9] == 2'h1 && status_out[7:0] == 8'h10)
        else $error("fixed status bits wrong");
    error_gate_a: assert property (perr_drive_out ==
        (event_in.perr_req_read && per_out))
        else $error("error line not gated by enable");
    read_word_a: assert property (cfg_in.rd && cfg_in.addr[7:2] == 6'h01
        |=> cfg_ack_out && cfg_rdata_out[31:16] == $past(status_out))
        else $error("status read wrong");
endmodule
bind pcs_status pcs_status_sva i_pcs_status_sva (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .event_in(event_in), .cfg_in(cfg_in),
    .cfg_ack_out(cfg_ack_out), .cfg_rdata_out(cfg_rdata_out),
    .perr_drive_out(perr_drive_out), .per_out(per_out),
    .status_out(status_out));
`default_nettype wire

// file: testbench/pcs_status_tb_top.sv
// self-checking bench for the bus status word
`timescale 1ns/1ps
`default_nettype none
module pcs_status_tb_top;
    import pcs_pkg::*;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    pcs_event_s ev_q = '0;
    pcs_cfg_req_s req_q = '0, cfg;
    logic ack, done, parity_response_enable, perr;
    logic [31:0] rdata, data;
    pcs_word_t status, st;
    int fail_count = 0;
    int samples_checked = 0;
    logic [8:0] evs [5] = '{9'h080, 9'h041, 9'h011, 9'h008, 9'h003};
    int pos [5] = '{14, 13, 12, 11, 8};
    initial forever #12.5 clk_in = ~clk_in;
    pcs_status i_pcs_status (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .event_in(ev_q), .cfg_in(cfg), .cfg_ack_out(ack),
        .cfg_rdata_out(rdata), .perr_drive_out(perr), .per_out(parity_response_enable),
        .status_out(status));
    pcs_host_model i_pcs_host_model (.clk_in(clk_in), .req_in(req_q),
        .ack_in(ack), .rdata_in(rdata), .cfg_out(cfg), .data_out(data),
        .done_out(done));
    task automatic chk(input string nm, input logic [31:0] e, s);
        samples_checked++;
        if (s !== e)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    // a read waits for the model's done under a bounded count
    task automatic cfg_op(input logic r, w, input logic [7:0] a,
        input logic [3:0] b, input logic [31:0] d, e);
        int n;
        n = 0;
        @(posedge clk_in) req_q <= '{r, w, a, b, d};
        @(posedge clk_in) req_q <= '0;
        #1;
        while (r && done !== 1'b1 && n < 20)
        begin
            @(posedge clk_in) #1;
            n++;
        end
        if (r) chk("read data", e, data);
    endtask
    task automatic ev_pulse(input pcs_event_s e);
        @(posedge clk_in) ev_q <= e;
        @(posedge clk_in) ev_q <= '0;
    endtask
    task automatic test_done();
        if (fail_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        st = 16'h0210;
        repeat (10) @(posedge clk_in);
        rst_n_in <= 1'b1;
        cfg_op(1, 0, 8'h06, 4'hF, 0, {st, 16'h0});
        cfg_op(0, 1, 8'h04, 4'hC, 32'hFFFF_FFFF, 0);
        ev_pulse(9'h061);
        ev_pulse(9'h010);
        ev_pulse(9'h009);
        ev_pulse(9'h005);
        @(posedge clk_in) ev_q <= 9'h002;
        #1 chk("error line off", 0, perr);
        @(posedge clk_in) ev_q <= '0;
        ev_pulse(9'h102);
        st[15] = 1'b1;
        cfg_op(1, 0, 8'h06, 4'hF, 0, {st, 16'h0});
        cfg_op(0, 1, 8'h04, 4'h1, 32'h0000_0040, 0);
        repeat (2) @(posedge clk_in);
        chk("parity enable", 1, parity_response_enable);
        @(posedge clk_in) ev_q <= 9'h002;
        #1 chk("error line on", 1, perr);
        @(posedge clk_in) ev_q <= '0;
        // each accepted event adds one sticky flag to the word
        foreach (evs[i])
        begin
            ev_pulse(evs[i]);
            st[pos[i]] = 1'b1;
            cfg_op(1, 0, 8'h06, 4'hF, 0, {st, 16'h0040});
        end
        cfg_op(1, 0, 8'h08, 4'hF, 0, 0);
        @(posedge clk_in) rst_n_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        cfg_op(1, 0, 8'h04, 4'hF, 0, 32'h0210_0000);
        test_done();
    end
    // a hang ends the run as a mismatch
    initial
    begin
        repeat (2000) @(posedge clk_in);
        fail_count++;
        test_done();
    end
endmodule
`default_nettype wire
